/* File: hdl/stm_timer.sv */
// The implementer's own choices: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
module stm_timer
  import stm_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic DBG_HALT,
  input wire logic CCP_IN,
  output logic CCP_OUT,
  output logic CCP_OE_N,
  output logic ADC_TRIG,
  output logic IRQ
);
  // -----------------------------------------
  // bus slave
  // -----------------------------------------
  logic ack;
  logic wr;
  logic [31:0] rd;
  logic [2:0] cfg;
  stm_mode_s mode;
  stm_ctl_s ctl;
  logic [2:0] imr;
  logic [2:0] ris;
  logic [2:0] mis;
  logic [15:0] ilr;
  logic [15:0] match;
  logic [7:0] pre;
  logic [15:0] cnt;
  logic [7:0] pcnt;
  logic [15:0] cap;
  logic pwm_lvl;
  logic [31:0] next_ilr;
  logic [31:0] next_reg;
  logic [2:0] icr_bits;
  logic ilr_wr;
  logic ctl_wr;
  stm_op_e op;

  // writes land on the edge where the master sees ack
  assign wr = WB_CYC_I && WB_STB_I && WB_WE_I && ack;
  assign WB_ACK_O = ack;
  assign ilr_wr = wr && WB_ADR_I == OFF_ILR;
  assign ctl_wr = wr && WB_ADR_I == OFF_CTL;
  assign next_ilr = stm_merge({16'h0000, ilr}, WB_DAT_I, WB_SEL_I);
  assign icr_bits = (wr && WB_ADR_I == OFF_ICR && WB_SEL_I[0]) ?
                    WB_DAT_I[2:0] : 3'h0;

  always_comb begin
    next_reg = 32'h0000_0000;
    case (WB_ADR_I)
      OFF_CFG: next_reg = {29'h0, cfg};
      OFF_MODE: next_reg = {28'h0, mode};
      OFF_CTL: next_reg = {26'h0, ctl};
      OFF_IMR: next_reg = {29'h0, imr};
      OFF_MATCH: next_reg = {16'h0, match};
      OFF_PRE: next_reg = {24'h0, pre};
      default: next_reg = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ack <= 1'b0;
    end else begin
      ack <= WB_CYC_I && WB_STB_I && !ack;
    end
  end

  always_comb begin
    rd = 32'h0000_0000;
    case (WB_ADR_I)
      OFF_CFG: rd = {29'h0, cfg};
      OFF_MODE: rd = {28'h0, mode};
      OFF_CTL: rd = {26'h0, ctl};
      OFF_IMR: rd = {29'h0, imr};
      OFF_RIS: rd = {29'h0, ris};
      OFF_MIS: rd = {29'h0, mis};
      OFF_ILR: rd = {16'h0, ilr};
      OFF_MATCH: rd = {16'h0, match};
      OFF_PRE: rd = {24'h0, pre};
      OFF_TVAL: rd = {16'h0, (op == OP_ETIME) ? cap : cnt};
      default: rd = 32'h0000_0000;
    endcase
  end

  // unmapped reads return zero, writes there are dropped
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      WB_DAT_O <= 32'h0000_0000;
    end else if (WB_CYC_I && WB_STB_I && !ack) begin
      WB_DAT_O <= rd;
    end
  end

  // -----------------------------------------
  // configuration registers
  // -----------------------------------------
  logic [31:0] merged;
  assign merged = stm_merge(next_reg, WB_DAT_I, WB_SEL_I);

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      cfg <= CFG_RST;
      mode <= '0;
      imr <= 3'h0;
      match <= 16'h0000;
      pre <= PRE_RST;
    end else if (wr) begin
      case (WB_ADR_I)
        OFF_CFG: cfg <= merged[2:0];
        OFF_MODE: mode <= merged[3:0];
        OFF_IMR: imr <= merged[2:0];
        OFF_MATCH: match <= merged[15:0];
        OFF_PRE: pre <= merged[7:0];
        default: cfg <= cfg;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ilr <= ILR_RST;
    end else if (ilr_wr) begin
      ilr <= next_ilr[15:0];
    end
  end

  // -----------------------------------------
  // mode decode and pin edges
  // -----------------------------------------
  logic run;
  logic hold;
  logic tmode;
  logic s1;
  logic s2;
  logic s3;
  logic edge_evt;
  logic to_evt;
  logic cm_evt;
  logic ce_evt;

  assign op = stm_decode(cfg, mode);
  assign run = ctl.en && op != OP_OFF;
  assign hold = ctl.stall && DBG_HALT;
  assign tmode = op == OP_ONE || op == OP_PER;

  // edges only from the second stage on; pin may be slow by two clocks
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end else begin
      s1 <= CCP_IN;
      s2 <= s1;
      s3 <= s2;
    end
  end

  always_comb begin
    case (ctl.evsel)
      EV_RISE: edge_evt = s2 && !s3;
      EV_FALL: edge_evt = !s2 && s3;
      EV_BOTH: edge_evt = s2 != s3;
      default: edge_evt = 1'b0;
    endcase
  end

  assign to_evt = run && !hold && tmode && cnt == 16'h0000;
  assign cm_evt = run && !hold && op == OP_ECNT && cnt == match;
  assign ce_evt = run && !hold && op == OP_ETIME && edge_evt;

  // -----------------------------------------
  // counter
  // -----------------------------------------
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      cnt <= ILR_RST;
      pcnt <= PRE_RST;
    end else if (ilr_wr) begin
      cnt <= next_ilr[15:0];
      pcnt <= pre;
    end else if (run && !hold) begin
      case (op)
        OP_ONE, OP_PER: begin
          if (cnt == 16'h0000) begin
            cnt <= ilr;
            pcnt <= pre;
          end else if (pcnt == 8'h00) begin
            cnt <= cnt - 16'h0001;
            pcnt <= pre;
          end else begin
            pcnt <= pcnt - 8'h01;
          end
        end
        OP_ECNT: begin
          if (cnt == match) begin
            cnt <= ilr;
          end else if (edge_evt) begin
            cnt <= cnt - 16'h0001;
          end
        end
        // prescaler bypassed here
        OP_ETIME, OP_PWM: begin
          cnt <= (cnt == 16'h0000) ? ilr : cnt - 16'h0001;
        end
        default: cnt <= cnt;
      endcase
    end
  end

  // software write to control wins over the self-clear
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctl <= '0;
    end else if (ctl_wr) begin
      ctl <= merged[5:0];
    end else if ((to_evt && op == OP_ONE) || cm_evt) begin
      ctl.en <= 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      cap <= 16'h0000;
    end else if (ce_evt) begin
      cap <= cnt;
    end
  end

  // -----------------------------------------
  // flags, trigger, pwm
  // -----------------------------------------
  logic [2:0] set;
  assign set = {ce_evt, cm_evt, to_evt};

  // a new event in the clear cycle survives
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ris <= 3'h0;
    end else begin
      ris <= (ris & ~icr_bits) | set;
    end
  end

  assign mis = ris & imr;
  assign IRQ = |mis;

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ADC_TRIG <= 1'b0;
    end else begin
      ADC_TRIG <= to_evt && ctl.ote;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      pwm_lvl <= 1'b0;
    end else if (op != OP_PWM || !run) begin
      pwm_lvl <= 1'b0;
    end else if (cnt == ilr) begin
      pwm_lvl <= 1'b1;
    end else if (cnt == match) begin
      pwm_lvl <= 1'b0;
    end
  end

  assign CCP_OUT = pwm_lvl ^ ctl.pwml;
  assign CCP_OE_N = op != OP_PWM;

  // -----------------------------------------
  // checks
  // -----------------------------------------
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);

  a_cfg_gate: assert property (
    cfg != CFG_SPLIT && !ilr_wr |=> cnt == $past(cnt))
    else $error("counter moved outside split mode");
  a_zero_reload: assert property (
    to_evt && !ilr_wr |=> cnt == $past(ilr) && pcnt == $past(pre))
    else $error("no reload after zero");
  a_oneshot_stop: assert property (
    to_evt && op == OP_ONE && !ctl_wr |=> !ctl.en)
    else $error("one-shot kept enable");
  a_periodic_run: assert property (
    to_evt && op == OP_PER && !ctl_wr |=> ctl.en)
    else $error("periodic lost enable");
  a_raw_sticky: assert property (
    ris[FL_TO] && !icr_bits[FL_TO] |=> ris[FL_TO])
    else $error("time-out flag dropped");
  a_adc_pulse: assert property (
    $rose(ADC_TRIG) |-> $past(to_evt) && $past(ctl.ote))
    else $error("trigger without enabled time-out");
  a_load_adopt: assert property (
    ilr_wr |=> cnt == ilr)
    else $error("load write not adopted");
  a_debug_freeze: assert property (
    hold && !ilr_wr |=> $stable(cnt) && $stable(pcnt))
    else $error("counter moved during halt");
  a_prescale_wait: assert property (
    run && tmode && !hold && !ilr_wr && cnt != 16'h0000
    && pcnt != 8'h00 |=> cnt == $past(cnt) && pcnt == $past(pcnt) - 8'h01)
    else $error("prescale step wrong");
  a_match_stop: assert property (
    cm_evt && !ctl_wr && !ilr_wr |=> !ctl.en && cnt == ilr && ris[FL_CM])
    else $error("edge count did not stop");
  a_capture_take: assert property (
    ce_evt |=> cap == $past(cnt) && ris[FL_CE])
    else $error("capture missed");
  a_pwm_quiet: assert property (
    op == OP_PWM |-> set == 3'h0)
    else $error("flag raised in pwm");
  a_pwm_rise: assert property (
    op == OP_PWM && run && cnt == ilr |=> pwm_lvl && CCP_OUT != ctl.pwml)
    else $error("pwm not asserted at load");
  a_oe_drive: assert property (
    op == OP_PWM |-> !CCP_OE_N)
    else $error("pin not driven in pwm");
  a_trig_gate: assert property (
    !(to_evt && ctl.ote) |=> !ADC_TRIG)
    else $error("trigger while not enabled");
  a_mask_irq: assert property (
    ris[FL_TO] && imr[FL_TO] |-> IRQ && mis[FL_TO])
    else $error("masked time-out not raised");
  a_ecnt_idle: assert property (
    op == OP_ECNT && !ctl.en && !ilr_wr |=> $stable(cnt))
    else $error("edge count moved while stopped");
  a_etime_free: assert property (
    op == OP_ETIME && run && !hold && !ilr_wr && cnt != 16'h0000
    |=> cnt == $past(cnt) - 16'h0001)
    else $error("edge time counter not free running");
  a_etime_wrap: assert property (
    op == OP_ETIME && run && !hold && !ilr_wr && cnt == 16'h0000
    |=> cnt == $past(ilr))
    else $error("edge time counter did not reload");
endmodule : stm_timer

/* File: hdl/stm_pkg.sv */
package stm_pkg;
  // -----------------------------------------
  // register offsets (byte addresses)
  // -----------------------------------------
  localparam logic [7:0] OFF_CFG = 8'h00;
  localparam logic [7:0] OFF_MODE = 8'h04;
  localparam logic [7:0] OFF_CTL = 8'h08;
  localparam logic [7:0] OFF_IMR = 8'h0c;
  localparam logic [7:0] OFF_RIS = 8'h10;
  localparam logic [7:0] OFF_MIS = 8'h14;
  localparam logic [7:0] OFF_ICR = 8'h18;
  localparam logic [7:0] OFF_ILR = 8'h1c;
  localparam logic [7:0] OFF_MATCH = 8'h20;
  localparam logic [7:0] OFF_PRE = 8'h24;
  localparam logic [7:0] OFF_TVAL = 8'h28;
  // -----------------------------------------
  // field values and reset values
  // -----------------------------------------
  localparam logic [2:0] CFG_SPLIT = 3'h4;
  localparam logic [1:0] MR_ONE = 2'h1;
  localparam logic [1:0] MR_PER = 2'h2;
  localparam logic [1:0] MR_CAP = 2'h3;
  localparam logic [1:0] EV_RISE = 2'h0;
  localparam logic [1:0] EV_FALL = 2'h1;
  localparam logic [1:0] EV_BOTH = 2'h3;
  localparam int FL_TO = 0;
  localparam int FL_CM = 1;
  localparam int FL_CE = 2;
  localparam logic [15:0] ILR_RST = 16'hffff;
  localparam logic [7:0] PRE_RST = 8'h00;
  localparam logic [2:0] CFG_RST = 3'h0;
  // -----------------------------------------
  // types
  // -----------------------------------------
  // mode register bits [3:0]
  typedef struct packed {
    logic ams;
    logic cmr;
    logic [1:0] mr;
  } stm_mode_s;
  // control register bits [5:0]
  typedef struct packed {
    logic pwml;
    logic ote;
    logic [1:0] evsel;
    logic stall;
    logic en;
  } stm_ctl_s;
  typedef enum logic [2:0] {
    OP_OFF = 3'b000,
    OP_ONE = 3'b001,
    OP_PER = 3'b010,
    OP_ECNT = 3'b011,
    OP_ETIME = 3'b100,
    OP_PWM = 3'b101
  } stm_op_e;
  // -----------------------------------------
  // helpers
  // -----------------------------------------
  function automatic stm_op_e stm_decode(input logic [2:0] cfg,
                                         input stm_mode_s m);
    stm_op_e op;
    op = OP_OFF;
    if (cfg == CFG_SPLIT) begin
      if (m.ams) begin
        if (!m.cmr && m.mr == MR_PER) op = OP_PWM;
      end else if (m.mr == MR_ONE) op = OP_ONE;
      else if (m.mr == MR_PER) op = OP_PER;
      else if (m.mr == MR_CAP) op = m.cmr ? OP_ETIME : OP_ECNT;
    end
    return op;
  endfunction : stm_decode
  function automatic logic [31:0] stm_merge(input logic [31:0] old,
                                            input logic [31:0] nw,
                                            input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) r[i*8 +: 8] = nw[i*8 +: 8];
    end
    return r;
  endfunction : stm_merge
endpackage : stm_pkg

/* File: test/stm_ccp_src.sv */
`timescale 1ns/1ps
// ----------------------------------------
// pin source on the far side
// ----------------------------------------
module stm_ccp_src (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic go,
  output logic pin
);
  logic [3:0] since;
  // edges closer than 4 clocks are refused, so each level holds at least four clocks
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin <= 1'b0;
      since <= 4'h0;
    end else if (go && since >= 4'h3) begin
      pin <= ~pin;
      since <= 4'h0;
    end else if (since != 4'hf) begin
      since <= since + 4'h1;
    end
  end
endmodule : stm_ccp_src

/* File: test/stm_timer_test.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_total++; \
  $display("[ERR] %0t got %0h want %0h", $time, (a), (b)); end end
module stm_timer_test;
  import stm_pkg::*;
  logic clk, rst_n, cyc, stb, we, halt, go, ack, pin, out, oe_n, trig, irq;
  logic [7:0] adr, rnd;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, q, v;
  logic [1:0] ev;
  wire ccp;
  int err_total, tests_run, cycles, tt, t1, k, p, n, c;
  // ----------------------------------------
  // design, pin source and wire level
  // ----------------------------------------
  assign ccp = !oe_n ? out : pin;
  stm_timer uut (.CORE_CLK(clk), .RST_N(rst_n), .WB_CYC_I(cyc),
    .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
    .WB_DAT_I(wdat), .WB_DAT_O(q), .WB_ACK_O(ack), .DBG_HALT(halt),
    .CCP_IN(ccp), .CCP_OUT(out), .CCP_OE_N(oe_n), .ADC_TRIG(trig),
    .IRQ(irq));
  stm_ccp_src src (.core_clk(clk), .rst_n(rst_n), .go(go), .pin(pin));
  // ----------------------------------------
  // clock, timeout and helpers
  // ----------------------------------------
  always #50 clk = ~clk;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      $display("[ERR] %0t timeout", $time);
      err_total++;
      results();
    end
  end
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  task automatic results();
    $display("checks %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : results
  // no cycle count assumed: wait for ack, the timeout ends a hang
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hf;
    do @(posedge clk); while (ack !== 1'b1);
    rdat = q;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    wb(1'b0, a, 32'h0);
  endtask : rd
  task automatic wtrig();
    do @(posedge clk); while (trig !== 1'b1);
    tt = cycles;
  endtask : wtrig
  task automatic count(input int m, input logic pwm);
    k = 0;
    repeat (m) begin
      @(posedge clk);
      if ((pwm ? out : trig) === 1'b1) k++;
    end
  endtask : count
  task automatic tog();
    go <= 1'b1;
    @(posedge clk);
    tt = cycles;
    go <= 1'b0;
    repeat (8) @(posedge clk);
  endtask : tog
  task automatic fin(input string s);
    $display("finished %s, mismatches so far %0d", s, err_total);
  endtask : fin
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {clk, rst_n, cyc, stb, we, halt, go, adr, sel, wdat} = '0;
    {err_total, tests_run, cycles} = '0;
    rnd = 8'h2f;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rd(OFF_ILR);
    `CHK(rdat[15:0], ILR_RST)
    rd(8'h3c);
    `CHK(rdat, 32'h0)
    `CHK(oe_n, 1'b1)
    wr(OFF_MODE, 32'(MR_PER));
    wr(OFF_ILR, 32'ha);
    wr(OFF_CTL, 32'h11);
    count(60, 1'b0);
    `CHK(k, 0)
    fin("config");
    rnd = lfsr(rnd);
    p = rnd[1:0];
    rnd = lfsr(rnd);
    n = 20 + rnd[4:0];
    wr(OFF_CFG, 32'(CFG_SPLIT));
    wr(OFF_CTL, 32'h0);
    wr(OFF_PRE, 32'(p));
    wr(OFF_ILR, 32'(n));
    wr(OFF_IMR, 32'h1);
    wr(OFF_CTL, 32'h11);
    wtrig();
    t1 = tt;
    wtrig();
    `CHK(tt - t1, n * (p + 1) + 1)
    @(posedge clk);
    `CHK(trig, 1'b0)
    rd(OFF_RIS);
    `CHK(rdat[FL_TO], 1'b1)
    rd(OFF_MIS);
    `CHK(rdat[FL_TO], 1'b1)
    `CHK(irq, 1'b1)
    wr(OFF_ICR, 32'h1);
    rd(OFF_RIS);
    `CHK(rdat[FL_TO], 1'b0)
    wr(OFF_CTL, 32'h13);
    wtrig();
    t1 = tt;
    halt <= 1'b1;
    repeat (30) @(posedge clk);
    halt <= 1'b0;
    wtrig();
    `CHK(tt - t1, n * (p + 1) + 31)
    wr(OFF_CTL, 32'h11);
    wr(OFF_ILR, 32'd200);
    wtrig();
    t1 = tt;
    // write lands three edges after the trigger, trigger seen two after zero
    wr(OFF_ILR, 32'd12);
    wtrig();
    `CHK(tt - t1, 12 * (p + 1) + 5)
    wr(OFF_CTL, 32'h01);
    wr(OFF_ICR, 32'h1);
    count(100, 1'b0);
    `CHK(k, 0)
    rd(OFF_RIS);
    `CHK(rdat[FL_TO], 1'b1)
    fin("periodic");
    wr(OFF_CTL, 32'h0);
    wr(OFF_MODE, 32'(MR_ONE));
    wr(OFF_ILR, 32'(n));
    wr(OFF_CTL, 32'h11);
    wtrig();
    rd(OFF_CTL);
    `CHK(rdat[0], 1'b0)
    count(300, 1'b0);
    `CHK(k, 0)
    fin("one-shot");
    wr(OFF_MODE, 32'(MR_CAP));
    for (int e = 0; e < 3; e++) begin
      ev = (e == 0) ? EV_RISE : (e == 1) ? EV_FALL : EV_BOTH;
      wr(OFF_ICR, 32'h7);
      // load minus match gives two edges to count
      wr(OFF_ILR, 32'h8);
      wr(OFF_MATCH, 32'h6);
      wr(OFF_CTL, 32'({ev, 2'b01}));
      c = 8;
      while (c != 6) begin
        tog();
        if (ev == EV_BOTH || pin == (ev == EV_RISE)) c--;
        if (c == 7) begin
          rd(OFF_TVAL);
          `CHK(rdat[15:0], 16'h7)
        end
      end
      rd(OFF_RIS);
      `CHK(rdat[FL_CM], 1'b1)
      rd(OFF_CTL);
      `CHK(rdat[0], 1'b0)
      tog();
      rd(OFF_TVAL);
      `CHK(rdat[15:0], 16'h8)
    end
    // edge select 2 picks no edge at all
    wr(OFF_CTL, 32'h9);
    tog();
    tog();
    rd(OFF_TVAL);
    `CHK(rdat[15:0], 16'h8)
    fin("edge count");
    wr(OFF_CTL, 32'h0);
    wr(OFF_ICR, 32'h7);
    wr(OFF_MODE, 32'h7);
    wr(OFF_ILR, 32'hffff);
    wr(OFF_CTL, 32'hd);
    tog();
    t1 = tt;
    rd(OFF_TVAL);
    v = rdat;
    tog();
    rd(OFF_TVAL);
    `CHK(v[15:0] - rdat[15:0], 16'(tt - t1))
    rd(OFF_RIS);
    `CHK(rdat[FL_CE], 1'b1)
    rd(OFF_TVAL);
    v = rdat;
    repeat (20) @(posedge clk);
    rd(OFF_TVAL);
    `CHK(rdat, v)
    fin("edge time");
    wr(OFF_CTL, 32'h0);
    wr(OFF_ICR, 32'h7);
    wr(OFF_MODE, 32'ha);
    wr(OFF_ILR, 32'd20);
    wr(OFF_MATCH, 32'd8);
    wr(OFF_CTL, 32'h1);
    repeat (25) @(posedge clk);
    count(21, 1'b1);
    `CHK(k, 12)
    `CHK(oe_n, 1'b0)
    wr(OFF_CTL, 32'h21);
    repeat (25) @(posedge clk);
    count(21, 1'b1);
    `CHK(k, 9)
    rd(OFF_RIS);
    `CHK(rdat[2:0], 3'h0)
    fin("pwm");
    results();
  end
endmodule : stm_timer_test
